// [rtl/serial_port_pkg.sv]
package serial_port_pkg;
	// device register map
	localparam int REG_COUNT = 12;
	localparam int ADDR_W = 5;
	localparam logic [4:0] REG_LAST = 5'h0B;
	localparam logic [4:0] ADDR_ALARM_FLAGS = 5'h02;
	localparam logic [4:0] ADDR_IFACE_POWER = 5'h03;
	localparam int FOUR_WIRE_SELECT_BIT = 6;
	localparam logic [7:0] ALARM_FLAG_MASK = 8'h03;
	localparam logic [7:0] REG_RESET [REG_COUNT] = '{
		8'h10, 8'h10, 8'h00, 8'h10, 8'h0F, 8'h00,
		8'h00, 8'h13, 8'h00, 8'h7A, 8'hB6, 8'hEA
	};

	// instruction byte layout
	localparam int INSTR_DIR_BIT = 7;
	localparam int BYTE_COUNT_HI_BIT = 6;
	localparam int BYTE_COUNT_LO_BIT = 5;
	localparam int ADDRESS_TOP_BIT = 4;

	// link timing
	localparam int MCLK_PERIOD_NS = 100;
	localparam int SCLK_HALF_NS = 800;
	localparam int SCLK_HALF_CYC = SCLK_HALF_NS / MCLK_PERIOD_NS;
	// read bits take three cycles to appear and two more to reach the host sampler
	localparam int SCLK_HALF_MIN = 6;

	// controller registers on the ahb side
	localparam logic [7:0] HOST_CTRL_OFS = 8'h00;
	localparam logic [7:0] HOST_TXDATA_OFS = 8'h04;
	localparam logic [7:0] HOST_RXDATA_OFS = 8'h08;
	localparam logic [7:0] HOST_STATUS_OFS = 8'h0C;
	localparam logic [7:0] HOST_IRQ_STAT_OFS = 8'h10;
	localparam logic [7:0] HOST_IRQ_CLR_OFS = 8'h14;
	localparam logic [7:0] HOST_IRQ_EN_OFS = 8'h18;
	localparam int CTRL_FOUR_WIRE_BIT = 8;
	localparam int CTRL_START_BIT = 9;
	localparam int IRQ_DONE_BIT = 0;

	typedef enum logic [1:0] {
		H_IDLE = 2'b00,
		H_SHIFT = 2'b01,
		H_CLOSE = 2'b10,
		H_GAP = 2'b11
	} host_state_t;
endpackage : serial_port_pkg

// [rtl/serial_link_if.sv]
`timescale 1ns/10ps
interface serial_link_if;
	logic sclk;
	logic frame_enable_n;
	logic host_sdio_o;
	logic host_sdio_oe;
	logic dev_sdio_o;
	logic dev_sdio_oe;
	logic dev_sdo_o;
	logic dev_sdo_oe;
	logic sdio;
	logic alarm_sdo;

	// wire levels from the enables; undriven pins idle high
	assign sdio = dev_sdio_oe ? dev_sdio_o : (host_sdio_oe ? host_sdio_o : 1'b1);
	assign alarm_sdo = dev_sdo_oe ? dev_sdo_o : 1'b1;

	modport host(output sclk, output frame_enable_n, output host_sdio_o, output host_sdio_oe,
		input sdio, input alarm_sdo);
	modport dev(input sclk, input frame_enable_n, input sdio,
		output dev_sdio_o, output dev_sdio_oe, output dev_sdo_o, output dev_sdo_oe);
endinterface : serial_link_if

// [rtl/sync2.sv]
`timescale 1ns/10ps
module sync2 #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic [WIDTH-1:0] d,
	output logic [WIDTH-1:0] q
);
	logic [WIDTH-1:0] meta_reg;

	if (WIDTH < 1) begin : g_chk
		$error("sync2 width must be at least one");
	end

	// first stage feeds only the second
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			meta_reg <= RESET_VAL;
			q <= RESET_VAL;
		end else begin
			meta_reg <= d;
			q <= meta_reg;
		end
	end
endmodule : sync2

// [rtl/serial_port_device.sv]
// Contract
// - wire mode from four_wire_select bit
// - three-wire reads drive the shared data pin
// - four-wire reads use separate output pin
// - sample on sclk rise, change on fall
// - host frames two to five bytes
// - instruction bit 7 high means read
// - bits 6:5 give one to four bytes
// - every byte moves msb first
// - bits 4:0 start address, counting down
// - instruction byte taken before read data
// - three-wire read leaves output pin floating
// - four-wire output low after last fall
// - written byte lands all eight bits together
// - writes to read-only bits have no effect
// - sticky bits hold until written zero
`timescale 1ns/10ps
module serial_port_device
	import serial_port_pkg::*;
(
	input wire logic mclk,
	input wire logic rstn,
	serial_link_if.dev link,
	input wire logic [1:0] alarm_event,
	output logic [8*REG_COUNT-1:0] reg_image
);
	logic [2:0] sync_q;
	logic sclk_s;
	logic frame_n_s;
	logic sdio_s;
	logic sclk_d_reg;
	logic [2:0] bit_cnt_reg;
	logic [2:0] byte_cnt_reg;
	logic [6:0] rx_reg;
	logic rw_reg;
	logic [2:0] nbytes_reg;
	logic [4:0] addr_reg;
	logic [7:0] tx_reg;
	logic sdio_o_reg;
	logic sdio_oe_reg;
	logic sdo_o_reg;
	logic sdo_oe_reg;
	logic [7:0] regs [REG_COUNT];

	// pins come from another domain: two flops before any use
	sync2 #(
		.WIDTH(3),
		.RESET_VAL(3'b010)
	) u_pin_sync (
		.clk(mclk),
		.rstn(rstn),
		.d({link.sclk, link.frame_enable_n, link.sdio}),
		.q(sync_q)
	);

	assign sclk_s = sync_q[2];
	assign frame_n_s = sync_q[1];
	assign sdio_s = sync_q[0];

	// edge finding on the synchronised serial clock
	logic active;
	logic sclk_rise;
	logic sclk_fall;
	assign active = ~frame_n_s;
	assign sclk_rise = active & sclk_s & ~sclk_d_reg;
	assign sclk_fall = active & ~sclk_s & sclk_d_reg;

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			sclk_d_reg <= 1'b0;
		end else begin
			sclk_d_reg <= sclk_s;
		end
	end

	// byte assembly and decode
	logic [7:0] rx_byte;
	logic byte_done;
	logic instr_done;
	logic data_done;
	logic wr_commit;
	logic read_phase;
	logic read_tail;
	logic four_wire;
	logic addr_mapped;
	logic [7:0] rd_data;
	logic [2:0] nbytes_next;

	assign rx_byte = {rx_reg, sdio_s};
	assign byte_done = sclk_rise & (bit_cnt_reg == 3'd7);
	assign instr_done = byte_done & (byte_cnt_reg == 3'd0);
	assign data_done = byte_done & (byte_cnt_reg != 3'd0) & (byte_cnt_reg <= nbytes_reg);
	// extra bytes past the declared count are ignored
	assign wr_commit = data_done & ~rw_reg;
	assign nbytes_next = {1'b0, rx_byte[BYTE_COUNT_HI_BIT:BYTE_COUNT_LO_BIT]} + 3'd1;
	assign read_phase = rw_reg & (byte_cnt_reg != 3'd0) & (byte_cnt_reg <= nbytes_reg);
	assign read_tail = rw_reg & (byte_cnt_reg == nbytes_reg + 3'd1);
	assign four_wire = regs[ADDR_IFACE_POWER[3:0]][FOUR_WIRE_SELECT_BIT];
	assign addr_mapped = (addr_reg <= REG_LAST);
	// unmapped addresses read as zero
	assign rd_data = addr_mapped ? regs[addr_reg[3:0]] : 8'h00;

	// frame sequencing; frame end drops any partial byte
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			bit_cnt_reg <= 3'd0;
			byte_cnt_reg <= 3'd0;
			rx_reg <= 7'h00;
			rw_reg <= 1'b0;
			nbytes_reg <= 3'd0;
			addr_reg <= 5'h00;
		end else if (!active) begin
			bit_cnt_reg <= 3'd0;
			byte_cnt_reg <= 3'd0;
			rw_reg <= 1'b0;
			nbytes_reg <= 3'd0;
		end else if (sclk_rise) begin
			rx_reg <= rx_byte[6:0];
			bit_cnt_reg <= bit_cnt_reg + 3'd1;
			if (byte_done && byte_cnt_reg != 3'd7) begin
				byte_cnt_reg <= byte_cnt_reg + 3'd1;
			end
			if (instr_done) begin
				rw_reg <= rx_byte[INSTR_DIR_BIT];
				nbytes_reg <= nbytes_next;
				addr_reg <= rx_byte[ADDRESS_TOP_BIT:0];
			end else if (data_done) begin
				addr_reg <= addr_reg - 5'd1;
			end
		end
	end

	// read data out; falling edge gives the host a full half period
	logic out_bit;
	logic load_byte;
	assign load_byte = (bit_cnt_reg == 3'd0);
	assign out_bit = load_byte ? rd_data[7] : tx_reg[7];

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			tx_reg <= 8'h00;
			sdio_o_reg <= 1'b0;
			sdio_oe_reg <= 1'b0;
			sdo_o_reg <= 1'b0;
			sdo_oe_reg <= 1'b0;
		end else if (!active) begin
			sdio_oe_reg <= 1'b0;
			sdo_oe_reg <= 1'b0;
			sdo_o_reg <= 1'b0;
		end else if (sclk_fall) begin
			if (read_phase) begin
				tx_reg <= load_byte ? {rd_data[6:0], 1'b0} : {tx_reg[6:0], 1'b0};
				if (four_wire) begin
					sdo_o_reg <= out_bit;
					sdo_oe_reg <= 1'b1;
					sdio_oe_reg <= 1'b0;
				end else begin
					sdio_o_reg <= out_bit;
					sdio_oe_reg <= 1'b1;
					sdo_oe_reg <= 1'b0;
				end
			end else if (read_tail) begin
				sdio_oe_reg <= 1'b0;
				sdo_o_reg <= 1'b0;
				sdo_oe_reg <= four_wire;
			end
		end
	end

	assign link.dev_sdio_o = sdio_o_reg;
	assign link.dev_sdio_oe = sdio_oe_reg;
	assign link.dev_sdo_o = sdo_o_reg;
	assign link.dev_sdo_oe = sdo_oe_reg;

	// register file: whole byte committed in one cycle
	for (genvar i = 0; i < REG_COUNT; i++) begin : g_reg
		logic hit;
		assign hit = wr_commit & (addr_reg == 5'(i));
		if (i == int'(ADDR_ALARM_FLAGS)) begin : g_sticky
			logic [7:0] sticky_next;
			// event set beats a clear in the same cycle
			assign sticky_next = ((hit ? (regs[i] & rx_byte) : regs[i])
				| {6'h00, alarm_event}) & ALARM_FLAG_MASK;
			always_ff @(posedge mclk or negedge rstn) begin
				if (!rstn) begin
					regs[i] <= REG_RESET[i];
				end else begin
					regs[i] <= sticky_next;
				end
			end
		end else begin : g_plain
			always_ff @(posedge mclk or negedge rstn) begin
				if (!rstn) begin
					regs[i] <= REG_RESET[i];
				end else if (hit) begin
					regs[i] <= rx_byte;
				end
			end
		end
		assign reg_image[8*i +: 8] = regs[i];
	end
	// addresses above the map have no storage, so writes vanish
endmodule : serial_port_device

// [rtl/serial_port_host.sv]
`timescale 1ns/10ps
module serial_port_host
	import serial_port_pkg::*;
#(
	parameter int HALF_CYC = SCLK_HALF_CYC
) (
	input wire logic mclk,
	input wire logic rstn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic hresp,
	output logic irq,
	serial_link_if.host link
);
	host_state_t state_reg;
	logic [1:0] pin_q;
	logic dp_wr_reg;
	logic [7:0] dp_addr_reg;
	logic [7:0] instr_reg;
	logic four_wire_reg;
	logic [31:0] txdata_reg;
	logic [31:0] rxdata_reg;
	logic [31:0] rx_sh_reg;
	logic [39:0] tx_sh_reg;
	logic [5:0] bit_idx_reg;
	logic [5:0] total_reg;
	logic [7:0] div_reg;
	logic irq_stat_reg;
	logic irq_en_reg;
	logic sclk_reg;
	logic frame_n_reg;
	logic sdio_o_reg;
	logic sdio_oe_reg;

	if (HALF_CYC < SCLK_HALF_MIN || HALF_CYC > 255) begin : g_chk
		$error("half period too short for the synchronisers or too long");
	end

	sync2 #(
		.WIDTH(2),
		.RESET_VAL(2'b11)
	) u_pin_sync (
		.clk(mclk),
		.rstn(rstn),
		.d({link.sdio, link.alarm_sdo}),
		.q(pin_q)
	);

	// ahb decode
	logic ap_take;
	logic wr_ctrl;
	logic start;
	logic wr_tx;
	logic wr_clr;
	logic wr_en;
	logic tick;
	logic done_evt;
	logic rx_bit;
	logic [5:0] total_next;
	logic [31:0] rd_mux;
	assign ap_take = hsel & htrans[1] & hready;
	assign wr_ctrl = dp_wr_reg & (dp_addr_reg == HOST_CTRL_OFS);
	assign wr_tx = dp_wr_reg & (dp_addr_reg == HOST_TXDATA_OFS);
	assign wr_clr = dp_wr_reg & (dp_addr_reg == HOST_IRQ_CLR_OFS);
	assign wr_en = dp_wr_reg & (dp_addr_reg == HOST_IRQ_EN_OFS);
	// start while busy is dropped
	assign start = wr_ctrl & hwdata[CTRL_START_BIT] & (state_reg == H_IDLE);
	assign tick = (div_reg == 8'(HALF_CYC - 1));
	assign done_evt = tick & (state_reg == H_GAP);
	assign rx_bit = four_wire_reg ? pin_q[0] : pin_q[1];
	assign total_next = {1'b0, hwdata[6:5] + 2'd0, 3'b000} + 6'd16;
	assign rd_mux = (haddr[7:0] == HOST_CTRL_OFS) ? {23'h0, four_wire_reg, instr_reg} :
		(haddr[7:0] == HOST_TXDATA_OFS) ? txdata_reg :
		(haddr[7:0] == HOST_RXDATA_OFS) ? rxdata_reg :
		(haddr[7:0] == HOST_STATUS_OFS) ? {31'h0, state_reg != H_IDLE} :
		(haddr[7:0] == HOST_IRQ_STAT_OFS) ? {31'h0, irq_stat_reg} :
		(haddr[7:0] == HOST_IRQ_EN_OFS) ? {31'h0, irq_en_reg} : 32'h0;

	// bus slave: zero wait, read data registered at address phase
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			dp_wr_reg <= 1'b0;
			dp_addr_reg <= 8'h00;
			hrdata <= 32'h0;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else begin
			dp_wr_reg <= ap_take & hwrite;
			dp_addr_reg <= haddr[7:0];
			if (ap_take && !hwrite) begin
				hrdata <= rd_mux;
			end
		end
	end

	// software registers; done beats a clear in the same cycle
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			instr_reg <= 8'h00;
			four_wire_reg <= 1'b0;
			txdata_reg <= 32'h0;
			irq_stat_reg <= 1'b0;
			irq_en_reg <= 1'b0;
			irq <= 1'b0;
		end else begin
			if (start) begin
				instr_reg <= hwdata[7:0];
				four_wire_reg <= hwdata[CTRL_FOUR_WIRE_BIT];
			end
			if (wr_tx) begin
				txdata_reg <= hwdata;
			end
			if (wr_en) begin
				irq_en_reg <= hwdata[IRQ_DONE_BIT];
			end
			irq_stat_reg <= done_evt | (irq_stat_reg & ~(wr_clr & hwdata[IRQ_DONE_BIT]));
			irq <= irq_stat_reg & irq_en_reg;
		end
	end

	// divider: one enable per sclk half period
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			div_reg <= 8'h00;
		end else if (start || tick) begin
			div_reg <= 8'h00;
		end else begin
			div_reg <= div_reg + 8'd1;
		end
	end

	// frame engine: drive on fall, sample on rise, msb first
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			state_reg <= H_IDLE;
			sclk_reg <= 1'b0;
			frame_n_reg <= 1'b1;
			sdio_o_reg <= 1'b0;
			sdio_oe_reg <= 1'b0;
			tx_sh_reg <= 40'h0;
			rx_sh_reg <= 32'h0;
			rxdata_reg <= 32'h0;
			bit_idx_reg <= 6'd0;
			total_reg <= 6'd0;
		end else begin
			case (state_reg)
				H_IDLE: begin
					if (start) begin
						tx_sh_reg <= {hwdata[7:0], txdata_reg};
						total_reg <= total_next;
						bit_idx_reg <= 6'd0;
						frame_n_reg <= 1'b0;
						sdio_o_reg <= hwdata[7];
						sdio_oe_reg <= 1'b1;
						state_reg <= H_SHIFT;
					end
				end
				H_SHIFT: begin
					if (tick && !sclk_reg) begin
						sclk_reg <= 1'b1;
						rx_sh_reg <= {rx_sh_reg[30:0], rx_bit};
						bit_idx_reg <= bit_idx_reg + 6'd1;
						tx_sh_reg <= {tx_sh_reg[38:0], 1'b0};
					end else if (tick) begin
						sclk_reg <= 1'b0;
						sdio_o_reg <= tx_sh_reg[39];
						// release the shared pin once read data may come back
						sdio_oe_reg <= ~(instr_reg[7] && bit_idx_reg >= 6'd8);
						if (bit_idx_reg == total_reg) begin
							sdio_oe_reg <= 1'b0;
							state_reg <= H_CLOSE;
						end
					end
				end
				H_CLOSE: begin
					if (tick) begin
						frame_n_reg <= 1'b1;
						rxdata_reg <= rx_sh_reg;
						state_reg <= H_GAP;
					end
				end
				H_GAP: begin
					if (tick) begin
						state_reg <= H_IDLE;
					end
				end
				default: begin
					state_reg <= H_IDLE;
				end
			endcase
		end
	end

	assign link.sclk = sclk_reg;
	assign link.frame_enable_n = frame_n_reg;
	assign link.host_sdio_o = sdio_o_reg;
	assign link.host_sdio_oe = sdio_oe_reg;
endmodule : serial_port_host

// [tb/serial_port_asserts.sv]
`timescale 1ns/10ps
module serial_port_asserts #(
	parameter int HALF = 4
) (
	input wire logic mclk,
	input wire logic rstn,
	input wire logic sclk,
	input wire logic frame_enable_n,
	input wire logic host_sdio_o,
	input wire logic host_sdio_oe,
	input wire logic dev_sdio_o,
	input wire logic dev_sdio_oe,
	input wire logic dev_sdo_o,
	input wire logic dev_sdo_oe
);
	logic [7:0] hi_cnt;

	// length of each sclk high phase, judged at the fall
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			hi_cnt <= 8'h00;
		end else begin
			hi_cnt <= sclk ? hi_cnt + 8'h01 : 8'h00;
		end
	end

	default clocking dcb @(posedge mclk);
	endclocking
	default disable iff (!rstn);

	property p_one_out_pin;
		!(dev_sdio_oe && dev_sdo_oe);
	endproperty
	a_one_out_pin: assert property (p_one_out_pin) else $error("device drives both pins");

	property p_no_fight;
		!(dev_sdio_oe && host_sdio_oe);
	endproperty
	a_no_fight: assert property (p_no_fight) else $error("both ends drive the data pin");

	property p_sdio_released;
		frame_enable_n |-> !dev_sdio_oe;
	endproperty
	a_sdio_released: assert property (p_sdio_released) else $error("data pin driven outside frame");

	property p_sdo_float;
		$rose(frame_enable_n) |-> ##[0:4] !dev_sdo_oe;
	endproperty
	a_sdo_float: assert property (p_sdo_float) else $error("output pin not floated");

	property p_sdo_low;
		dev_sdo_oe && frame_enable_n |-> !dev_sdo_o;
	endproperty
	a_sdo_low: assert property (p_sdo_low) else $error("output pin not low at frame end");

	property p_dev_change;
		($changed(dev_sdio_o) && dev_sdio_oe && $past(dev_sdio_oe)) or
			($changed(dev_sdo_o) && dev_sdo_oe && $past(dev_sdo_oe)) |-> !sclk;
	endproperty
	a_dev_change: assert property (p_dev_change) else $error("device data moved while sclk high");

	property p_host_hold;
		sclk && $past(sclk) && host_sdio_oe |-> $stable(host_sdio_o);
	endproperty
	a_host_hold: assert property (p_host_hold) else $error("host data moved while sclk high");

	property p_half;
		$fell(sclk) |-> hi_cnt == HALF;
	endproperty
	a_half: assert property (p_half) else $error("sclk high phase wrong length");

	property p_idle_clk;
		frame_enable_n |-> !sclk;
	endproperty
	a_idle_clk: assert property (p_idle_clk) else $error("sclk high outside frame");

	property p_instr_first;
		$fell(frame_enable_n) |-> (!dev_sdio_oe && !dev_sdo_oe) [*8];
	endproperty
	a_instr_first: assert property (p_instr_first) else $error("device drove during instruction");
endmodule : serial_port_asserts

// [tb/serial_register_port_bench.sv]
`timescale 1ns/10ps
module serial_register_port_bench;
	import serial_port_pkg::*;
	localparam int HALF = SCLK_HALF_CYC;
	logic mclk, rstn, hsel, hwrite, hreadyout, hresp, irq;
	logic [31:0] haddr, hwdata, hrdata, rx, sdio_bits, sdo_bits;
	logic [1:0] htrans, alarm_event;
	logic [2:0] hsize;
	logic [8*REG_COUNT-1:0] reg_image;
	int bad_count, check_count;

	serial_link_if serial_link_if_i();
	serial_port_host #(.HALF_CYC(HALF)) serial_port_host_i(.mclk(mclk), .rstn(rstn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .irq(irq),
		.link(serial_link_if_i.host));
	serial_port_device serial_port_device_i(.mclk(mclk), .rstn(rstn), .link(serial_link_if_i.dev),
		.alarm_event(alarm_event), .reg_image(reg_image));
	serial_port_asserts #(.HALF(HALF)) serial_port_asserts_i(.mclk(mclk), .rstn(rstn),
		.sclk(serial_link_if_i.sclk), .frame_enable_n(serial_link_if_i.frame_enable_n),
		.host_sdio_o(serial_link_if_i.host_sdio_o), .host_sdio_oe(serial_link_if_i.host_sdio_oe),
		.dev_sdio_o(serial_link_if_i.dev_sdio_o), .dev_sdio_oe(serial_link_if_i.dev_sdio_oe),
		.dev_sdo_o(serial_link_if_i.dev_sdo_o), .dev_sdo_oe(serial_link_if_i.dev_sdo_oe));

	initial begin
		mclk = 1'h0;
		forever #50 mclk = ~mclk;
	end

	// wire monitor: last 32 bits seen on each pin at sclk rise
	always @(negedge serial_link_if_i.frame_enable_n) begin
		sdio_bits = 32'h0;
		sdo_bits = 32'h0;
	end
	always @(posedge serial_link_if_i.sclk) begin
		sdio_bits = {sdio_bits[30:0], serial_link_if_i.sdio};
		sdo_bits = {sdo_bits[30:0], serial_link_if_i.alarm_sdo};
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			bad_count++;
			$display("BAD at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	// one single transfer; read data lands in rx
	task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		hsel <= 1'h1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h0, a};
		do @(posedge mclk); while (hreadyout !== 1'h1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge mclk); while (hreadyout !== 1'h1);
		rx = hrdata;
	endtask : ahb

	// launch one serial frame and wait for busy to drop, bounded
	task automatic frame(input logic fw, input logic [7:0] instr, input logic [31:0] tx);
		int n;
		ahb(1'h1, HOST_TXDATA_OFS, tx);
		ahb(1'h1, HOST_CTRL_OFS, {22'h0, 1'h1, fw, instr});
		n = 0;
		do begin
			ahb(1'h0, HOST_STATUS_OFS, 32'h0);
			n++;
		end while (rx[0] !== 1'h0 && n < 2000);
		check({31'h0, rx[0]}, 32'h0);
		repeat (3) @(posedge mclk);
		ahb(1'h0, HOST_RXDATA_OFS, 32'h0);
	endtask : frame

	task automatic t_reset;
		for (int i = 0; i < REG_COUNT; i++) begin
			check({24'h0, reg_image[8*i+:8]}, {24'h0, REG_RESET[i]});
		end
		ahb(1'h0, 8'h20, 32'h0);
		check(rx, 32'h0);
		check({31'h0, hresp}, 32'h0);
	endtask : t_reset

	// three bytes down from 0x06, then done interrupt raised and cleared
	task automatic t_write_burst;
		ahb(1'h1, HOST_IRQ_EN_OFS, 32'h1);
		frame(1'h0, 8'h46, 32'hAABBCC00);
		check(sdio_bits, 32'h46AABBCC);
		check({8'h0, reg_image[55:32]}, 32'h00AABBCC);
		check({24'h0, reg_image[63:56]}, 32'h13);
		check({31'h0, irq}, 32'h1);
		ahb(1'h1, HOST_IRQ_CLR_OFS, 32'h1);
		repeat (2) @(posedge mclk);
		check({31'h0, irq}, 32'h0);
	endtask : t_write_burst

	// four bytes read from 0x0B on the shared pin, with the interrupt masked
	task automatic t_read_3wire;
		ahb(1'h1, HOST_IRQ_EN_OFS, 32'h0);
		frame(1'h0, 8'hEB, 32'h0);
		check(rx, 32'hEAB67A00);
		check(sdio_bits, 32'hEAB67A00);
		check(sdo_bits, 32'hFFFFFFFF);
		check({31'h0, irq}, 32'h0);
		ahb(1'h0, HOST_IRQ_STAT_OFS, 32'h0);
		check({31'h0, rx[0]}, 32'h1);
		ahb(1'h1, HOST_IRQ_EN_OFS, 32'h1);
		repeat (2) @(posedge mclk);
		check({31'h0, irq}, 32'h1);
		ahb(1'h1, HOST_IRQ_CLR_OFS, 32'h1);
	endtask : t_read_3wire

	// alarm flags: read-only upper bits, sticky until written zero
	task automatic t_sticky;
		@(posedge mclk);
		alarm_event <= 2'h3;
		@(posedge mclk);
		alarm_event <= 2'h0;
		repeat (2) @(posedge mclk);
		check({24'h0, reg_image[23:16]}, 32'h03);
		frame(1'h0, 8'h02, 32'hFE000000);
		check({24'h0, reg_image[23:16]}, 32'h02);
		frame(1'h0, 8'h82, 32'h0);
		check({24'h0, rx[7:0]}, 32'h02);
		frame(1'h0, 8'h02, 32'h0);
		check({24'h0, reg_image[23:16]}, 32'h00);
	endtask : t_sticky

	// switch to four wires, read 0x07 and 0x06 on the separate pin
	task automatic t_four_wire;
		frame(1'h0, 8'h03, 32'h50000000);
		check({24'h0, reg_image[31:24]}, 32'h50);
		frame(1'h1, 8'hA7, 32'h0);
		check({16'h0, rx[15:0]}, 32'h13AA);
		check({16'h0, sdo_bits[15:0]}, 32'h13AA);
		check({16'h0, sdio_bits[15:0]}, 32'hFFFF);
		check({31'h0, serial_link_if_i.alarm_sdo}, 32'h1);
	endtask : t_four_wire

	task automatic wrap_up;
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : wrap_up

	initial begin
		rstn = 1'h0;
		hsel = 1'h0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'h0;
		hsize = 3'h2;
		hwdata = 32'h0;
		alarm_event = 2'h0;
		bad_count = 0;
		check_count = 0;
		repeat (16) @(posedge mclk);
		rstn <= 1'h1;
		t_reset();
		t_write_burst();
		t_read_3wire();
		t_sticky();
		t_four_wire();
		wrap_up();
	end

	// all frames need well under a millisecond
	initial begin
		#3000000;
		bad_count++;
		wrap_up();
	end
endmodule : serial_register_port_bench
